// ### hdl/pco_clock_out.sv
// synthesizer control and clock-out pin source selector, APB slave
// Operation
// - intermediate rate is crystal times feedback factor, halved.
// - synthesizer output is intermediate rate divided by output divider.
// - source 0 GPIO, 1 synthesizer, 2 low, 3 high.
// - sources 4 to 7 give crystal divided by 1, 2, 4, 8.
// - sources 8, 9, A toggle pin on timer 0, 2, 3 overflow.
// - pin carries selected clock only while clock-out enable set.
// - feedback field 00,01,10,11 selects 23,27,28,23.
// - output divider 8 to 254; software never writes 0 to 7.
//
// Decided for this implementation: the APB interface to the registers.
module pco_clock_out
  import pco_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pco_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer overflow pulses
  input wire logic timerZeroOvf,
  input wire logic timerTwoOvf,
  input wire logic timerThreeOvf,
  // general-purpose drive of the pin
  input wire logic gpioPinOut,
  input wire logic gpioPinOenN,
  // clock-out pin
  input wire logic clockOutPinIn,
  output logic clockOutPinOut,
  output logic clockOutPinOenN
);
  import pco_pkg::*;

  logic [1:0] rstSync_ff;
  logic rstN;
  pco_byte_t ctrl_ff, nxt_ctrl;
  pco_byte_t div_ff, nxt_div;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [XCNT_W-1:0] xCnt_ff, nxt_xCnt;
  logic tmrTog_ff, nxt_tmrTog;
  logic pinOut_ff, nxt_pinOut;
  logic pinOenN_ff, nxt_pinOenN;
  logic mapped;
  logic wrStb;
  logic clkEn;
  logic pwrDown;
  pco_src_e src;
  logic tmrOvf;

  pco_synth_if sy ();

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstN = rstSync_ff[1];

  // ------------------------------------------------------------
  // apb register file
  // ------------------------------------------------------------
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_DIV) ||
    (paddr == ADDR_STAT);
  assign wrStb = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_ff;

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_div = div_ff;
    nxt_rdata = rdata_ff;
    if (wrStb && paddr == ADDR_CTRL)
      nxt_ctrl = pwdata[7:0];
    if (wrStb && paddr == ADDR_DIV)
      nxt_div = pwdata[7:0];
    if (psel && !penable)
    begin
      case (paddr)
        ADDR_CTRL: nxt_rdata = {24'h000000, ctrl_ff};
        ADDR_DIV: nxt_rdata = {24'h000000, div_ff};
        ADDR_STAT: nxt_rdata = {29'h0000000, clockOutPinIn, sy.run,
          sy.synthClk};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_ff <= CTRL_RST;
      div_ff <= DIV_RST;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      div_ff <= nxt_div;
      rdata_ff <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // synthesizer
  // ------------------------------------------------------------
  assign clkEn = ctrl_ff[EN_BIT];
  assign pwrDown = ctrl_ff[PD_BIT];
  assign src = pco_src_e'(ctrl_ff[SEL_HI:SEL_LO]);

  always_comb
  begin
    case (ctrl_ff[FB_HI:FB_LO])
      2'h1: sy.fbFactor = FB_27;
      2'h2: sy.fbFactor = FB_28;
      default: sy.fbFactor = FB_23;
    endcase
    sy.divValue = div_ff;
    sy.run = !pwrDown;
  end

  pco_synth_div u_div (
    .clock(clock),
    .rstN(rstN),
    .sy(sy.div)
  );

  // ------------------------------------------------------------
  // crystal divider and timer toggle
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_xCnt = xCnt_ff + XCNT_W'(1);
    case (src)
      SRC_TMR0: tmrOvf = timerZeroOvf;
      SRC_TMR2: tmrOvf = timerTwoOvf;
      SRC_TMR3: tmrOvf = timerThreeOvf;
      default: tmrOvf = 1'b0;
    endcase
    nxt_tmrTog = tmrOvf ? !tmrTog_ff : tmrTog_ff;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      xCnt_ff <= '0;
      tmrTog_ff <= 1'b0;
    end
    else
    begin
      xCnt_ff <= nxt_xCnt;
      tmrTog_ff <= nxt_tmrTog;
    end
  end

  // ------------------------------------------------------------
  // pin source selector
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_pinOenN = 1'b0;
    case (src)
      SRC_GPIO:
      begin
        nxt_pinOut = gpioPinOut;
        nxt_pinOenN = gpioPinOenN;
      end
      SRC_SYNTH: nxt_pinOut = sy.synthClk && sy.run;
      SRC_LOW: nxt_pinOut = 1'b0;
      SRC_HIGH: nxt_pinOut = 1'b1;
      SRC_XTAL1: nxt_pinOut = xCnt_ff[2];
      SRC_XTAL2: nxt_pinOut = xCnt_ff[3];
      SRC_XTAL4: nxt_pinOut = xCnt_ff[4];
      SRC_XTAL8: nxt_pinOut = xCnt_ff[5];
      SRC_TMR0, SRC_TMR2, SRC_TMR3: nxt_pinOut = tmrTog_ff;
      default: nxt_pinOut = 1'b0;
    endcase
    if (!clkEn && src != SRC_GPIO)
    begin
      nxt_pinOut = 1'b0;
      nxt_pinOenN = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      pinOut_ff <= 1'b0;
      pinOenN_ff <= 1'b1;
    end
    else
    begin
      pinOut_ff <= nxt_pinOut;
      pinOenN_ff <= nxt_pinOenN;
    end
  end

  assign clockOutPinOut = pinOut_ff;
  assign clockOutPinOenN = pinOenN_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  property p_fb_decode;
    ctrl_ff[FB_HI:FB_LO] == 2'h2 |-> sy.fbFactor == FB_28;
  endproperty
  a_fb_decode: assert property (p_fb_decode)
    else $error("feedback factor decode wrong");

  property p_force_low;
    clkEn && src == SRC_LOW |=> !pinOut_ff && !pinOenN_ff;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("pin not held low");

  property p_xtal;
    clkEn && src == SRC_XTAL1 |=> pinOut_ff == $past(xCnt_ff[2]);
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal clock not on pin");

  sequence s_ovf0;
    clkEn && src == SRC_TMR0 && timerZeroOvf;
  endsequence
  sequence s_hold0;
    clkEn && src == SRC_TMR0 && !timerZeroOvf;
  endsequence
  property p_tmr_toggle;
    s_ovf0 ##1 s_hold0 |=> pinOut_ff != $past(pinOut_ff);
  endproperty
  a_tmr_toggle: assert property (p_tmr_toggle)
    else $error("timer overflow did not toggle pin");

  property p_disabled;
    !clkEn && src != SRC_GPIO |=> pinOenN_ff && !pinOut_ff;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("pin driven while clock-out disabled");

  property p_pd_pin;
    (pwrDown && src == SRC_SYNTH) [*2] |=> !pinOut_ff;
  endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("synthesizer clock on pin while powered down");
endmodule : pco_clock_out

// ### hdl/pco_pkg.sv
// constants and types for the synthesizer and clock-out control block
package pco_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_CTRL = 8'h3D;
  localparam logic [7:0] IDX_DIV = 8'h3E;
  localparam logic [7:0] IDX_STAT = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 4;
  localparam int EN_BIT = 3;
  localparam int PD_BIT = 2;
  localparam int FB_HI = 1;
  localparam int FB_LO = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h08;
  localparam logic [7:0] DIV_MIN = 8'h08;
  // ------------------------------------------------------------
  // synthesizer figures
  // ------------------------------------------------------------
  localparam int XTAL_KHZ = 27120;
  localparam logic [4:0] FB_23 = 5'h17;
  localparam logic [4:0] FB_27 = 5'h1B;
  localparam logic [4:0] FB_28 = 5'h1C;
  localparam int CLK_SCALE = 8;
  localparam int ACC_W = 12;
  localparam int XCNT_W = 6;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef logic [7:0] pco_byte_t;
  typedef enum logic [3:0] {
    SRC_GPIO = 4'h0,
    SRC_SYNTH = 4'h1,
    SRC_LOW = 4'h2,
    SRC_HIGH = 4'h3,
    SRC_XTAL1 = 4'h4,
    SRC_XTAL2 = 4'h5,
    SRC_XTAL4 = 4'h6,
    SRC_XTAL8 = 4'h7,
    SRC_TMR0 = 4'h8,
    SRC_TMR2 = 4'h9,
    SRC_TMR3 = 4'hA
  } pco_src_e;
endpackage : pco_pkg

// ### hdl/pco_synth_if.sv
// signals between clock-out control and synthesizer divider
interface pco_synth_if;
  logic [4:0] fbFactor;
  logic [7:0] divValue;
  logic run;
  logic synthClk;
  logic tick;
  modport ctrl (output fbFactor, output divValue, output run,
    input synthClk, input tick);
  modport div (input fbFactor, input divValue, input run,
    output synthClk, output tick);
endinterface : pco_synth_if

// ### hdl/pco_synth_div.sv
// two-stage synthesizer model: feedback multiply-halve, output divide
module pco_synth_div
  import pco_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstN,
  // control side
  pco_synth_if.div sy
);
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic clk_ff;
  logic nxt_clk;
  logic [7:0] effDiv;
  logic [ACC_W-1:0] thr;
  logic [ACC_W-1:0] sum;

  // ------------------------------------------------------------
  // accumulator
  // ------------------------------------------------------------
  always_comb
  begin
    effDiv = (sy.divValue < DIV_MIN) ? DIV_MIN : sy.divValue;
    thr = ACC_W'(effDiv) * ACC_W'(CLK_SCALE);
    sum = acc_ff + ACC_W'(sy.fbFactor);
    nxt_acc = sum;
    nxt_clk = clk_ff;
    sy.tick = 1'b0;
    if (!sy.run)
    begin
      nxt_acc = '0;
      nxt_clk = 1'b0;
    end
    else if (sum >= thr)
    begin
      nxt_acc = sum - thr;
      nxt_clk = !clk_ff;
      sy.tick = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      acc_ff <= '0;
      clk_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      clk_ff <= nxt_clk;
    end
  end

  assign sy.synthClk = clk_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  property p_acc_step;
    sy.run && !sy.tick |=>
      acc_ff == $past(acc_ff) + ACC_W'($past(sy.fbFactor));
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("accumulator did not add feedback factor");

  property p_out_toggle;
    sy.run && (sum >= thr) |=> clk_ff != $past(clk_ff);
  endproperty
  a_out_toggle: assert property (p_out_toggle)
    else $error("output clock missed divider wrap");

  property p_div_floor;
    thr >= ACC_W'(DIV_MIN) * ACC_W'(CLK_SCALE);
  endproperty
  a_div_floor: assert property (p_div_floor)
    else $error("output divider below eight");

  property p_pd_stop;
    !sy.run [*2] |-> acc_ff == '0 && !clk_ff && !sy.tick;
  endproperty
  a_pd_stop: assert property (p_pd_stop)
    else $error("synthesizer runs while powered down");
endmodule : pco_synth_div

// ### bench/tb.sv
// self-checking bench for the synthesizer and clock-out control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pco_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, pv;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0] dv;
  logic [2:0] tmr;
  logic gpioOut, gpioOenN, pinIn, pinOut, pinOenN;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int tog;
  int want;

  pco_clock_out u_pco_clock_out (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerZeroOvf(tmr[0]), .timerTwoOvf(tmr[1]),
    .timerThreeOvf(tmr[2]), .gpioPinOut(gpioOut),
    .gpioPinOenN(gpioOenN), .clockOutPinIn(pinIn),
    .clockOutPinOut(pinOut), .clockOutPinOenN(pinOenN));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic int fbv(input logic [1:0] c);
    case (c)
      2'h1: return 27;
      2'h2: return 28;
      default: return 23;
    endcase
  endfunction : fbv

  task automatic test_done();
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic chk_n(input string nm, input int e, g);
    checked++;
    if (g < e - 1 || g > e + 1)
    begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
      fail_count++;
    end
  endtask : chk_n

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setc(input logic [3:0] s, input logic en, pd,
    input logic [1:0] fb);
    apb(1'b1, ADDR_CTRL, {24'h000000, s, en, pd, fb});
    repeat (3) @(posedge clock);
  endtask : setc

  task automatic count_tog(input int n);
    logic p;
    tog = 0;
    p = pinOut;
    repeat (n)
    begin
      @(posedge clock);
      if (pinOut !== p)
        tog++;
      p = pinOut;
    end
  endtask : count_tog
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 32'h8D81;
    {rst_n, psel, penable, pwrite, tmr, gpioOut, gpioOenN} = '0;
    {pinIn, paddr, pwdata} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    chk("ctrl err", 32'h0, {31'h0, err});
    apb(1'b0, ADDR_DIV, 32'h0);
    chk("div reset", 32'h8, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 4; i++)
    begin
      setc(SRC_GPIO, 1'b0, 1'b0, 2'h0);
      {gpioOut, gpioOenN, pinIn} <= 3'(xs());
      repeat (3) @(posedge clock);
      chk("gpio out", {31'h0, gpioOut}, {31'h0, pinOut});
      chk("gpio oen", {31'h0, gpioOenN}, {31'h0, pinOenN});
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("pin in", {31'h0, pinIn}, {31'h0, rd[2]});
    end
    setc(SRC_LOW, 1'b1, 1'b0, 2'h0);
    chk("low", 32'h0, {30'h0, pinOut, pinOenN});
    setc(SRC_HIGH, 1'b1, 1'b0, 2'h0);
    chk("high", 32'h2, {30'h0, pinOut, pinOenN});
    setc(SRC_HIGH, 1'b0, 1'b0, 2'h0);
    chk("disabled", 32'h1, {30'h0, pinOut, pinOenN});
    for (int k = 0; k < 4; k++)
    begin
      setc(4'(SRC_XTAL1 + k), 1'b1, 1'b0, 2'h0);
      count_tog(256);
      chk_n("xtal toggles", 64 >> k, tog);
    end
    setc(SRC_XTAL1, 1'b0, 1'b0, 2'h0);
    count_tog(256);
    chk_n("xtal disabled", 0, tog);
    for (int i = 0; i < 4; i++)
    begin
      dv = (i == 0) ? 8'h08 : (i == 3) ? 8'hFE : 8'(8 + xs() % 247);
      apb(1'b1, ADDR_DIV, {24'h0, dv});
      apb(1'b0, ADDR_DIV, 32'h0);
      chk("div rw", {24'h0, dv}, rd);
      setc(SRC_SYNTH, 1'b1, 1'b0, 2'(i));
      // let the accumulator settle below a smaller new wrap point
      repeat (64) @(posedge clock);
      count_tog(1024);
      want = 1024 * fbv(2'(i)) / (CLK_SCALE * dv);
      chk_n("synth toggles", want, tog);
    end
    setc(SRC_SYNTH, 1'b1, 1'b1, 2'h0);
    count_tog(256);
    chk_n("pd toggles", 0, tog);
    chk("pd level", 32'h0, {31'h0, pinOut});
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("pd status", 32'h0, {31'h0, rd[1]});
    for (int i = 0; i < 3; i++)
    begin
      setc(4'(SRC_TMR0 + i), 1'b1, 1'b0, 2'h0);
      for (int j = 0; j < 3; j++)
      begin
        pv = pinOut;
        @(posedge clock);
        tmr <= 3'(1 << j);
        @(posedge clock);
        tmr <= 3'h0;
        repeat (3) @(posedge clock);
        chk("timer toggle", {31'h0, pv ^ (i == j)}, {31'h0, pinOut});
      end
    end
    setc(4'hB, 1'b1, 1'b0, 2'h0);
    chk("reserved code", 32'h0, {30'h0, pinOut, pinOenN});
    test_done();
  end
endmodule : tb
